// file: verilog/comparator_pkg.sv
// Shared constants for the analog comparator control logic.
// Assumes one byte-wide special-function register bus on clk_sys.
package comparator_pkg;

   // Register location on the special-function register bus
   localparam logic [7:0] CTRL_ADDR        = 8'h9a;
   localparam logic [7:0] CTRL_PAGE        = 8'h00;
   localparam logic [7:0] CTRL_RESET       = 8'h00;

   // Field positions inside comparator_control
   localparam int         ENABLE_BIT       = 7;
   localparam int         OUT_STATE_BIT    = 6;
   localparam int         RISE_FLAG_BIT    = 5;
   localparam int         FALL_FLAG_BIT    = 4;
   localparam int         POS_HYST_MSB     = 3;
   localparam int         POS_HYST_LSB     = 2;
   localparam int         NEG_HYST_MSB     = 1;
   localparam int         NEG_HYST_LSB     = 0;

   // Hysteresis select encodings, same for both fields
   localparam logic [1:0] HYST_OFF         = 2'h0;
   localparam logic [1:0] HYST_5MV         = 2'h1;
   localparam logic [1:0] HYST_10MV        = 2'h2;
   localparam logic [1:0] HYST_20MV        = 2'h3;

   // Synchroniser depth for the analog comparator result
   localparam int         SYNC_STAGES      = 3;

   typedef logic [1:0] hyst_sel_t;

endpackage

// file: verilog/cmp_sync_if.sv
// Carrier between the input synchroniser and the register logic.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface cmp_sync_if;
   logic state;   // Filtered comparator result
   logic rise;    // One-cycle pulse, accepted low-to-high change
   logic fall;    // One-cycle pulse, accepted high-to-low change

   modport producer (output state, output rise, output fall);
   modport consumer (input state, input rise, input fall);
endinterface

// file: verilog/cmp_input_sync.sv
// Synchroniser and edge detector for the comparator result.
// Assumes raw_in is asynchronous to clk_sys; ce freezes all state.
`timescale 1ns/1ps
module cmp_input_sync
   import comparator_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       ce,
   input  wire logic       raw_in,
   cmp_sync_if.producer    sync
);

   logic [SYNC_STAGES-1:0] sync_q;
   logic                   state_q;
   logic                   agree;

   // The agree test reads stages 1 and 2 by index, so the depth is fixed
   if (SYNC_STAGES != 3) begin : g_depth_check
      $error("synchroniser depth must be three stages");
   end

   // Three-stage shift; stage 0 feeds stage 1 only
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync_q <= '0;
      end else if (ce) begin
         sync_q <= {sync_q[SYNC_STAGES-2:0], raw_in};
      end
   end

   // A change counts only once the last two stages agree
   assign agree = (sync_q[1] == sync_q[2]);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= 1'b0;
      end else if (ce && agree) begin
         state_q <= sync_q[2];
      end
   end

   // Edge pulses lead the state update by one edge
   assign sync.state = state_q;
   assign sync.rise  = ce && agree && sync_q[2] && !state_q;
   assign sync.fall  = ce && agree && !sync_q[2] && state_q;

   property p_rise_sets_state;
      @(posedge clk_sys) disable iff (reset)
      sync.rise |=> state_q;
   endproperty
   a_rise_sets_state: assert property (p_rise_sets_state)
      else $error("rise pulse without state going high");

   property p_fall_clears_state;
      @(posedge clk_sys) disable iff (reset)
      sync.fall |=> !state_q;
   endproperty
   a_fall_clears_state: assert property (p_fall_clears_state)
      else $error("fall pulse without state going low");

endmodule

// file: verilog/analog_comparator_control.sv
// Control and status register for the analog comparator.
// Assumes the processor bus presents address, page and strobes on clk_sys,
// and that the analog comparator result arrives asynchronously.
`timescale 1ns/1ps

// Operation
// - Bit 6 reads 1 when the positive input is above the negative input and 0 otherwise.
// - Bit 5 is set by a low-to-high change of the comparator result and stays set.
// - Bit 4 is set by a high-to-low change of the comparator result and stays set.
// - Hardware never clears the edge flags; a software write of 0 clears them unless an edge arrives in the same cycle.
// - Bits 3:2 pick positive hysteresis: off, 5 mV, 10 mV or 20 mV.
// - Bits 1:0 pick negative hysteresis with the same encoding.
// - Spurious edges after power-on or a setting change are recorded, not suppressed.
module analog_comparator_control
   import comparator_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       ce,
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_page,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       cmp_result,
   output logic            comparator_enable,
   output hyst_sel_t       positive_hysteresis_select,
   output hyst_sel_t       negative_hysteresis_select
);

   cmp_sync_if             cmp_sig ();

   logic                   enable_q;
   logic                   rise_flag_q;
   logic                   rise_flag_d;
   logic                   fall_flag_q;
   logic                   fall_flag_d;
   hyst_sel_t              pos_hyst_q;
   hyst_sel_t              neg_hyst_q;
   logic [7:0]             rdata_q;
   logic                   hit;
   logic                   wr_hit;
   logic                   rd_hit;
   logic                   rise_event;
   logic                   fall_event;
   logic [7:0]             ctrl_view;

   // Result synchroniser and edge detector
   cmp_input_sync u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .ce      (ce),
      .raw_in  (cmp_result),
      .sync    (cmp_sig.producer)
   );

   // Address decode; both address and page must match
   assign hit    = (sfr_addr == CTRL_ADDR) && (sfr_page == CTRL_PAGE);
   assign wr_hit = ce && sfr_wr && hit;
   assign rd_hit = ce && sfr_rd && hit;

   // Edges only count while enabled; no blanking after settings change
   assign rise_event = cmp_sig.rise && enable_q;
   assign fall_event = cmp_sig.fall && enable_q;

   // Enable bit
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         enable_q <= CTRL_RESET[ENABLE_BIT];
      end else if (wr_hit) begin
         enable_q <= sfr_wdata[ENABLE_BIT];
      end
   end

   // Hysteresis fields, decoded by the analog front end
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pos_hyst_q <= CTRL_RESET[POS_HYST_MSB:POS_HYST_LSB];
         neg_hyst_q <= CTRL_RESET[NEG_HYST_MSB:NEG_HYST_LSB];
      end else if (wr_hit) begin
         pos_hyst_q <= sfr_wdata[POS_HYST_MSB:POS_HYST_LSB];
         neg_hyst_q <= sfr_wdata[NEG_HYST_MSB:NEG_HYST_LSB];
      end
   end

   // Sticky flags: an edge in the write cycle beats the clear
   always_comb begin
      rise_flag_d = rise_flag_q;
      fall_flag_d = fall_flag_q;
      if (wr_hit) begin
         rise_flag_d = sfr_wdata[RISE_FLAG_BIT];
         fall_flag_d = sfr_wdata[FALL_FLAG_BIT];
      end
      if (rise_event) begin
         rise_flag_d = 1'b1;
      end
      if (fall_event) begin
         fall_flag_d = 1'b1;
      end
   end

   // Flag registers; ce low holds them as they are
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rise_flag_q <= CTRL_RESET[RISE_FLAG_BIT];
         fall_flag_q <= CTRL_RESET[FALL_FLAG_BIT];
      end else if (ce) begin
         rise_flag_q <= rise_flag_d;
         fall_flag_q <= fall_flag_d;
      end
   end

   // Register image; output state is read-only
   always_comb begin
      ctrl_view                             = 8'h00;
      ctrl_view[ENABLE_BIT]                 = enable_q;
      ctrl_view[OUT_STATE_BIT]              = cmp_sig.state;
      ctrl_view[RISE_FLAG_BIT]              = rise_flag_q;
      ctrl_view[FALL_FLAG_BIT]              = fall_flag_q;
      ctrl_view[POS_HYST_MSB:POS_HYST_LSB]  = pos_hyst_q;
      ctrl_view[NEG_HYST_MSB:NEG_HYST_LSB]  = neg_hyst_q;
   end

   // Read data registered one cycle after the strobe; misses read zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata_q <= 8'h00;
      end else if (ce) begin
         rdata_q <= rd_hit ? ctrl_view : 8'h00;
      end
   end

   assign sfr_rdata                  = rdata_q;
   assign comparator_enable          = enable_q;
   assign positive_hysteresis_select = pos_hyst_q;
   assign negative_hysteresis_select = neg_hyst_q;

   // Read of bit 6 shows the filtered result of the read cycle
   property p_read_out_state;
      @(posedge clk_sys) disable iff (reset)
      rd_hit |=> (sfr_rdata[OUT_STATE_BIT] == $past(cmp_sig.state));
   endproperty
   a_read_out_state: assert property (p_read_out_state)
      else $error("read of output state bit is wrong");

   property p_rise_sets_flag;
      @(posedge clk_sys) disable iff (reset)
      (cmp_sig.rise && enable_q) |=> rise_flag_q;
   endproperty
   a_rise_sets_flag: assert property (p_rise_sets_flag)
      else $error("rising edge did not set flag");

   property p_fall_sets_flag;
      @(posedge clk_sys) disable iff (reset)
      (cmp_sig.fall && enable_q) |=> fall_flag_q;
   endproperty
   a_fall_sets_flag: assert property (p_fall_sets_flag)
      else $error("falling edge did not set flag");

   property p_flags_hold;
      @(posedge clk_sys) disable iff (reset)
      (rise_flag_q && !wr_hit) |=> rise_flag_q;
   endproperty
   a_flags_hold: assert property (p_flags_hold)
      else $error("rising flag cleared without a write");

   property p_write_zero_clears;
      @(posedge clk_sys) disable iff (reset)
      (wr_hit && !sfr_wdata[FALL_FLAG_BIT] && !fall_event) |=> !fall_flag_q;
   endproperty
   a_write_zero_clears: assert property (p_write_zero_clears)
      else $error("write of zero did not clear falling flag");

   property p_pos_hyst_write;
      @(posedge clk_sys) disable iff (reset)
      wr_hit |=> (positive_hysteresis_select == $past(sfr_wdata[POS_HYST_MSB:POS_HYST_LSB]));
   endproperty
   a_pos_hyst_write: assert property (p_pos_hyst_write)
      else $error("positive hysteresis select not taken");

   property p_neg_hyst_write;
      @(posedge clk_sys) disable iff (reset)
      wr_hit |=> (negative_hysteresis_select == $past(sfr_wdata[NEG_HYST_MSB:NEG_HYST_LSB]));
   endproperty
   a_neg_hyst_write: assert property (p_neg_hyst_write)
      else $error("negative hysteresis select not taken");

   property p_edge_after_setting_change;
      @(posedge clk_sys) disable iff (reset)
      (wr_hit && sfr_wdata[ENABLE_BIT]) ##1 cmp_sig.rise |=> rise_flag_q;
   endproperty
   a_edge_after_setting_change: assert property (p_edge_after_setting_change)
      else $error("edge right after enable was dropped");

   property p_disabled_no_set;
      @(posedge clk_sys) disable iff (reset)
      (!enable_q && !wr_hit && !rise_flag_q && !fall_flag_q) |=> (!rise_flag_q && !fall_flag_q);
   endproperty
   a_disabled_no_set: assert property (p_disabled_no_set)
      else $error("edge flag set while disabled");

   // Falling flag is as sticky as the rising one
   property p_fall_flag_holds;
      @(posedge clk_sys) disable iff (reset)
      (fall_flag_q && !wr_hit) |=> fall_flag_q;
   endproperty
   a_fall_flag_holds: assert property (p_fall_flag_holds)
      else $error("falling flag cleared without a write");

   property p_write_zero_clears_rise;
      @(posedge clk_sys) disable iff (reset)
      (wr_hit && !sfr_wdata[RISE_FLAG_BIT] && !rise_event) |=> !rise_flag_q;
   endproperty
   a_write_zero_clears_rise: assert property (p_write_zero_clears_rise)
      else $error("write of zero did not clear rising flag");

   // Clock enable low freezes every register, flags included
   property p_ce_low_freezes;
      @(posedge clk_sys) disable iff (reset)
      !ce |=> ($stable(enable_q) && $stable(rise_flag_q) && $stable(fall_flag_q)
               && $stable(pos_hyst_q) && $stable(neg_hyst_q) && $stable(sfr_rdata));
   endproperty
   a_ce_low_freezes: assert property (p_ce_low_freezes)
      else $error("state moved while clock enable was low");

   // Read data stands for one enabled cycle only, then falls back to zero
   property p_rdata_idle_zero;
      @(posedge clk_sys) disable iff (reset)
      (ce && !rd_hit) |=> (sfr_rdata == 8'h00);
   endproperty
   a_rdata_idle_zero: assert property (p_rdata_idle_zero)
      else $error("read data not zero outside a read");

endmodule

// file: verification/analog_input_model.sv
// Behavioural analog front end that feeds the comparator control block.
// Assumes levels in millivolts are changed by the bench between reads.
`timescale 1ns/1ps
module analog_input_model (
   input  int   positive_mv,
   input  int   negative_mv,
   output logic cmp_result
);
   // Ideal compare; hysteresis is analog and not modelled here
   always_comb begin
      cmp_result = (positive_mv > negative_mv);
   end
endmodule

// file: verification/analog_comparator_control_test.sv
// Self-checking bench for the comparator control register.
// Assumes the register bus contract of the block and a 200 MHz clk_sys.
`timescale 1ns/1ps
module analog_comparator_control_test;
   import comparator_pkg::*;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        ce = 1'b1;
   logic        sfr_wr = 1'b0;
   logic        sfr_rd = 1'b0;
   logic [7:0]  sfr_addr = 8'h00;
   logic [7:0]  sfr_page = 8'h00;
   logic [7:0]  sfr_wdata = 8'h00;
   logic [7:0]  sfr_rdata;
   logic [7:0]  got;
   logic        cmp_result;
   logic        comparator_enable;
   hyst_sel_t   positive_hysteresis_select;
   hyst_sel_t   negative_hysteresis_select;
   logic [31:0] seed = 32'h00007f8b;
   int          positive_mv = 0;
   int          negative_mv = 100;
   int          fail_count = 0;
   int          compares = 0;
   int          m_en = 0, m_out = 0, m_rf = 0, m_ff = 0, m_hp = 0, m_hn = 0;

   // 5 ns period
   always #2.5 clk_sys = ~clk_sys;

   analog_input_model u_analog_input_model (.positive_mv(positive_mv), .negative_mv(negative_mv),
      .cmp_result(cmp_result));

   analog_comparator_control u_analog_comparator_control (.clk_sys(clk_sys), .reset(reset), .ce(ce),
      .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .cmp_result(cmp_result), .comparator_enable(comparator_enable),
      .positive_hysteresis_select(positive_hysteresis_select),
      .negative_hysteresis_select(negative_hysteresis_select));

   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // Expected register image from the integer model
   function automatic logic [7:0] img();
      return {m_en[0], m_out[0], m_rf[0], m_ff[0], m_hp[1:0], m_hn[1:0]};
   endfunction

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Single write; the model follows only a mapped hit, bit 6 never
   task automatic wr(input logic [7:0] a, input logic [7:0] pg, input logic [7:0] d);
      @(posedge clk_sys);
      #1 sfr_addr = a;
      sfr_page = pg;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge clk_sys);
      #1 sfr_wr = 1'b0;
      if (a == CTRL_ADDR && pg == CTRL_PAGE && ce) begin
         m_en = d[7];
         m_rf = d[5];
         m_ff = d[4];
         m_hp = d[3:2];
         m_hn = d[1:0];
      end
      chk({3'h0, comparator_enable, positive_hysteresis_select, negative_hysteresis_select},
          {3'h0, m_en[0], m_hp[1:0], m_hn[1:0]});
   endtask

   // Read data lands in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      #1 sfr_addr = a;
      sfr_page = CTRL_PAGE;
      sfr_rd = 1'b1;
      @(posedge clk_sys);
      #1 sfr_rd = 1'b0;
      got = sfr_rdata;
   endtask

   // Move the input, give the synchroniser ample time, then update the model
   task automatic set_in(input int v);
      @(posedge clk_sys);
      #1 positive_mv = v ? 200 : 0;
      repeat (8) @(posedge clk_sys);
      if (v != m_out && m_en != 0) begin
         if (v != 0) m_rf = 1;
         else m_ff = 1;
      end
      m_out = v;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Guard against a hang
   initial begin
      repeat (100000) @(posedge clk_sys);
      fail_count++;
      wrap_up();
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      #1 reset = 1'b0;
      rd(CTRL_ADDR); chk(got, CTRL_RESET);
      for (int i = 0; i < 4; i++) begin
         wr(CTRL_ADDR, CTRL_PAGE, 8'h40 | 8'(i * 4) | 8'(3 - i));
         rd(CTRL_ADDR); chk(got, img());
      end
      wr(CTRL_ADDR, CTRL_PAGE, 8'h80);
      set_in(1);
      rd(CTRL_ADDR); chk(got, img());
      set_in(0);
      rd(CTRL_ADDR); chk(got, img());
      repeat (60) @(posedge clk_sys);
      rd(CTRL_ADDR); chk(got, img());
      wr(CTRL_ADDR, CTRL_PAGE, 8'h80);
      rd(CTRL_ADDR); chk(got, img());
      wr(CTRL_ADDR, CTRL_PAGE, 8'h00);
      set_in(1);
      rd(CTRL_ADDR); chk(got, img());
      set_in(0);
      rd(CTRL_ADDR); chk(got, img());
      // Wrong address and wrong page must leave the register alone
      wr(8'h9b, CTRL_PAGE, 8'hbf);
      wr(CTRL_ADDR, 8'h01, 8'hbf);
      rd(8'h9b); chk(got, 8'h00);
      rd(CTRL_ADDR); chk(got, img());
      @(posedge clk_sys);
      #1 chk(sfr_rdata, 8'h00);
      // Clock enable low: the strobe is ignored and nothing moves
      @(posedge clk_sys);
      #1 ce = 1'b0;
      wr(CTRL_ADDR, CTRL_PAGE, 8'hbf);
      ce = 1'b1;
      rd(CTRL_ADDR); chk(got, img());
      // Input edge timed to be accepted the cycle after the enabling write
      @(posedge clk_sys);
      #1 positive_mv = 200;
      @(posedge clk_sys);
      wr(CTRL_ADDR, CTRL_PAGE, 8'h80);
      m_rf = 1;
      m_out = 1;
      repeat (4) @(posedge clk_sys);
      rd(CTRL_ADDR); chk(got, img());
      // Random settings and input moves, model checked at each read
      for (int i = 0; i < 40; i++) begin
         seed = xorshift(seed);
         wr(CTRL_ADDR, CTRL_PAGE, seed[7:0]);
         set_in(int'(seed[8]));
         rd(CTRL_ADDR); chk(got, img());
      end
      wrap_up();
   end
endmodule
